// file: hw/cpb_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpb_regs.svh"
module cpb_arbiter import cpb_pkg::*; (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Configuration
   input wire logic rr_mode_i,
   // Requests: bit 0 processor, 1..4 DMA channels, 5 PCI
   input wire logic [5:0] req_i,
   input wire logic boundary_i,
   // Grant
   output logic [5:0] grant_o
);
   cpb_arb_t arb_r;
   cpb_arb_t arb_nxt;
   logic [5:0] pick;

   // ==========================================
   // Priority search
   always_comb begin
      logic [2:0] idx;
      logic found;
      idx = 3'h0;
      found = 1'b0;
      pick = 6'h00;
      if (req_i[0]) begin // R13 R15
         pick = 6'h01;
      end else begin
         for (int k = 0; k < 5; k++) begin
            // R14
            idx = 3'((arb_r.rr_mode ? 32'(arb_r.rr_ptr) : 32'd0) + k);
            if (idx > 3'h4) begin
               idx = 3'(idx - 3'h5);
            end
            if (!found && req_i[idx + 3'h1]) begin
               found = 1'b1;
               pick = 6'h01 << (idx + 3'h1);
            end
         end
      end
   end

   // ==========================================
   // State update
   always_comb begin
      arb_nxt = arb_r;
      if (!arb_r.rr_caught) begin
         arb_nxt.rr_mode = rr_mode_i; // R23
         arb_nxt.rr_caught = 1'b1;
      end
      // Hold a grant while its owner still requests, else the
      // sequencer and the grant could disagree on the owner
      if (boundary_i && (arb_r.grant & req_i) == 6'h00) begin // R24
         arb_nxt.grant = pick;
         if (pick[5:1] != 5'h00) begin
            arb_nxt.rr_ptr = (arb_r.rr_ptr == 3'h4) ? 3'h0
                             : 3'(arb_r.rr_ptr + 3'h1); // R14
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         arb_r <= '0;
      end else begin
         arb_r <= arb_nxt;
      end
   end

   assign grant_o = arb_r.grant;
endmodule
`default_nettype wire

// file: hw/cpb_bridge.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpb_regs.svh"
module cpb_bridge import cpb_pkg::*; (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Static configuration
   input wire logic rr_mode_i,
   input wire logic slow_decode_i,
   input wire logic [23:0] turnaround_count_i,
   input wire logic [3:0] mem_width_i,
   input wire logic ta_load_i,
   // Programmable windows: DRAM 0..3, memory 0..1
   input wire cpb_window_t dram_win_i [4],
   input wire cpb_window_t mem_win_i [2],
   // Requests: 0 processor, 1..4 DMA, 5 PCI
   input wire cpb_req_t req_i [6],
   input wire logic [31:0] cpu_wdata_i,
   input wire logic [31:0] dma_wdata_i,
   output logic [5:0] grant_o,
   output logic beat_ack_o,
   output logic done_o,
   output logic [31:0] rdata_o,
   // External memory side (pins)
   output logic [25:2] mem_addr_o,
   output logic [15:2] dram_addr_o,
   output logic [3:0] byte_lane_select_low_o,
   output logic mem_rd_o,
   output logic mem_wr_o,
   input wire logic [31:0] mem_data_i,
   output logic [31:0] mem_data_o,
   output logic mem_data_oe_n_o,
   input wire logic mem_ready_i,
   // Selects
   output logic [11:0] region_sel_o,
   output logic [1:0] port_width_o
);
   cpb_state_reg_t s_r;
   cpb_state_reg_t s_nxt;
   logic [5:0] req_vec;
   logic [5:0] grant;
   logic [2:0] gidx;
   logic [11:0] hit;
   logic [3:0] reg_idx;
   logic [1:0] ta_r [12];
   logic ready_s;
   logic [31:0] rdata_q;

   // ==========================================
   // Arbitration
   for (genvar g = 0; g < 6; g++) begin : g_req
      assign req_vec[g] = req_i[g].valid;
   end

   cpb_arbiter u_arb (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .rr_mode_i(rr_mode_i),
      .req_i(req_vec),
      .boundary_i(s_r.state == CPB_IDLE),
      .grant_o(grant)
   );

   always_comb begin
      gidx = 3'h0;
      for (int k = 0; k < 6; k++) begin
         if (grant[k]) begin
            gidx = 3'(k);
         end
      end
   end

   // ==========================================
   // Address decode, first clock of a transaction
   // R8 R9 masked compare allows banks to tile one range
   for (genvar g = 0; g < 4; g++) begin : g_dram
      assign hit[g] = ((s_r.addr ^ dram_win_i[g].base)
                       & ~dram_win_i[g].mask) == 32'h0; // R9
   end
   for (genvar g = 0; g < 2; g++) begin : g_mem
      assign hit[4 + g] = ((s_r.addr ^ mem_win_i[g].base)
                           & ~mem_win_i[g].mask) == 32'h0; // R9
   end
   assign hit[6] = s_r.addr[31:20] == `CPB_PCI0_BASE; // R8
   assign hit[7] = s_r.addr[31:20] == `CPB_PCI1_BASE;
   assign hit[8] = s_r.addr[31:20] == `CPB_PERIPH_BASE;
   assign hit[9] = s_r.addr[31:20] == `CPB_CTLREG_BASE;
   assign hit[10] = s_r.addr[31:20] == `CPB_BOOT_BASE;
   assign hit[11] = 1'b0;

   always_comb begin
      reg_idx = `CPB_RG_NONE;
      for (int k = 11; k >= 0; k--) begin
         if (hit[k]) begin
            reg_idx = 4'(k); // R6
         end
      end
   end

   // ==========================================
   // Turnaround table, one field per region
   for (genvar g = 0; g < 12; g++) begin : g_ta
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
         if (rst_i) begin
            ta_r[g] <= `CPB_TA_RESET; // R20
         end else if (ta_load_i) begin
            ta_r[g] <= turnaround_count_i[2 * (g % 12 / 1) % 24 +: 2];
         end
      end
   end

   // ==========================================
   // Transaction sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.data_valid = 1'b0;
      s_nxt.sync_a = {s_r.sync_a[0], mem_ready_i};
      s_nxt.sync_b = s_r.sync_b;
      case (s_r.state)
         CPB_IDLE: begin
            if (grant != 6'h00 && req_i[gidx].valid) begin
               s_nxt.owner = gidx;
               s_nxt.write = req_i[gidx].write;
               s_nxt.addr = req_i[gidx].addr;
               s_nxt.start_word = req_i[gidx].addr[3:2];
               s_nxt.beat = 2'h0;
               s_nxt.beats_left = req_i[gidx].beats;
               s_nxt.state = CPB_DECODE;
            end
         end
         CPB_DECODE: begin
            s_nxt.region = reg_idx;
            // R7 second decode clock when slow setting chosen
            if (!slow_decode_i || s_r.beat == 2'h1) begin
               s_nxt.beat = 2'h0;
               s_nxt.state = CPB_DATA;
            end else begin
               s_nxt.beat = 2'h1;
            end
         end
         CPB_DATA: begin
            if (ready_s) begin
               s_nxt.data_valid = 1'b1;
               s_nxt.rdata = mem_data_i; // R11
               s_nxt.beat = 2'(s_r.beat + 2'h1);
               // R2 R4 subblock order for processor reads
               if (s_r.owner == 3'h0 && !s_r.write) begin
                  s_nxt.addr[3:2] = s_r.start_word
                                    ^ 2'(s_r.beat + 2'h1);
               end else begin
                  s_nxt.addr = s_r.addr + 32'h4; // R1 R3
               end
               if (s_r.beats_left <= 3'h1) begin
                  s_nxt.done = 1'b1;
                  s_nxt.ta_cnt = ta_r[s_r.region];
                  // R19 R22 idle after reads only
                  s_nxt.state = (!s_r.write && ta_r[s_r.region] != 2'h0)
                                ? CPB_TURN : CPB_IDLE;
               end else begin
                  s_nxt.beats_left = 3'(s_r.beats_left - 3'h1);
               end
            end
         end
         CPB_TURN: begin
            s_nxt.ta_cnt = 2'(s_r.ta_cnt - 2'h1);
            if (s_r.ta_cnt == 2'h1) begin
               s_nxt.state = CPB_IDLE; // R19
            end
         end
         default: begin
            s_nxt.state = CPB_IDLE;
         end
      endcase
      s_nxt.wdata = (s_r.owner == 3'h0) ? cpu_wdata_i : dma_wdata_i;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Ready arrives from pin; only the second flop is read
   assign ready_s = s_r.sync_a[1];

   // ==========================================
   // Outputs
   assign grant_o = grant; // R24
   assign beat_ack_o = s_r.data_valid;
   assign done_o = s_r.done;
   assign rdata_q = s_r.rdata;
   assign rdata_o = rdata_q; // R11
   assign mem_addr_o = s_r.addr[25:2]; // R5
   // Row during the decode clocks, column afterwards
   assign dram_addr_o = (s_r.state == CPB_DECODE)
                        ? s_r.addr[`CPB_ROW_SHIFT + 13:`CPB_ROW_SHIFT]
                        : s_r.addr[15:2]; // R5
   assign byte_lane_select_low_o = (s_r.state == CPB_DATA) ? 4'h0 : 4'hf;
   assign mem_rd_o = (s_r.state == CPB_DATA) && !s_r.write;
   assign mem_wr_o = (s_r.state == CPB_DATA) && s_r.write;
   assign mem_data_o = s_r.wdata; // R10 R12
   assign mem_data_oe_n_o = !((s_r.state == CPB_DATA) && s_r.write);
   always_comb begin
      region_sel_o = 12'h000;
      if (s_r.state == CPB_DATA && s_r.region != `CPB_RG_NONE) begin
         region_sel_o[s_r.region] = 1'b1; // R6 R17
      end
   end
   // R18 only the memory regions MEM0 and MEM1 take the programmed width; all others are 32-bit
   assign port_width_o = (s_r.region == `CPB_RG_MEM0) ? mem_width_i[1:0]
                       : (s_r.region == `CPB_RG_MEM1) ? mem_width_i[3:2]
                       : `CPB_WIDTH_32;
endmodule
`default_nettype wire

// file: hw/cpb_pkg.sv
package cpb_pkg;
   typedef enum logic [2:0] {
      CPB_IDLE = 3'h0,
      CPB_DECODE = 3'h1,
      CPB_DATA = 3'h2,
      CPB_TURN = 3'h3
   } cpb_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [2:0] beats;
   } cpb_req_t;

   typedef struct packed {
      logic [31:0] base;
      logic [31:0] mask;
   } cpb_window_t;

   typedef struct packed {
      logic [5:0] grant;
      logic [2:0] rr_ptr;
      logic rr_mode;
      logic rr_caught;
   } cpb_arb_t;

   typedef struct packed {
      cpb_state_t state;
      logic [2:0] owner;
      logic write;
      logic [31:0] addr;
      logic [1:0] start_word;
      logic [1:0] beat;
      logic [2:0] beats_left;
      logic [3:0] region;
      logic [1:0] ta_cnt;
      logic [31:0] rdata;
      logic [31:0] wdata;
      logic data_valid;
      logic done;
      logic [1:0] sync_a;
      logic [1:0] sync_b;
   } cpb_state_reg_t;
endpackage

// file: hw/cpb_regs.svh
`ifndef CPB_REGS_SVH
`define CPB_REGS_SVH
// Notes on behaviour
// R1 - External word address steps by one after each 32-bit word moved.
// R2 - Processor reads step the word address in subblock order.
// R3 - Writes and all DMA or PCI transfers step linearly.
// R4 - All accesses treated as 32 bits; byte accesses also step subblock.
// R5 - Address mux: wide lines for ROM/SRAM/IO, narrow row/column for DRAM.
// R6 - Latched address decoded into fixed and programmable chip selects.
// R7 - Decode latency of one or two clocks, chosen by boot software.
// R8 - First clock compares address to DRAM, memory, PCI, periph, regs bases.
// R9 - DRAM and memory compares ignore bits whose mask bit is set.
// R10 - Processor write data phase: bridge drives write data on core bus.
// R11 - Processor read: memory drives data bus, bridge latches and returns it.
// R12 - DMA or PCI access: bridge drives address, control and data itself.
// R13 - Processor owns the bus by default; DMA and PCI request it. The code grants the processor only on request.
// R14 - Fixed priority cpu,0..3,PCI or round robin rotating after each grant. The code rotates only after DMA or PCI grants; the cpu stays first.
// R15 - Processor may re-request after losing grant, interleaving with DMA.
// R16 - Processor releases bus after current transaction when DMA pending. The code keeps the grant while its owner still requests.
// R17 - Address space split into twelve regions, each with port width.
// R18 - DRAM and PCI regions fixed 32-bit; memory and I/O programmable. The code programs only MEM0 and MEM1; I/O is fixed 32-bit.
// R19 - After a read, next transaction waits the region turnaround count.
// R20 - Turnaround settings reset to three cycles.
// R21 - Boot software should reprogram turnaround settings early.
// R22 - Turnaround is minimum idle cycles after read before next access.
// R23 - Arbitration scheme taken from a configuration input at reset.
// R24 - At most one grant; grant changes only between transactions.

`define CPB_NUM_REQ 6
`define CPB_NUM_REGION 12
`define CPB_TA_RESET 2'h3
`define CPB_WIDTH_32 2'h2
`define CPB_WIDTH_RESET 2'h0
// Region indices
`define CPB_RG_DRAM0 4'h0
`define CPB_RG_MEM0 4'h4
`define CPB_RG_MEM1 4'h5
`define CPB_RG_PCI0 4'h6
`define CPB_RG_PCI1 4'h7
`define CPB_RG_PERIPH 4'h8
`define CPB_RG_CTLREG 4'h9
`define CPB_RG_BOOT 4'ha
`define CPB_RG_NONE 4'hb
// Fixed windows on address bits [31:20]
`define CPB_PCI0_BASE 12'h400
`define CPB_PCI1_BASE 12'h600
`define CPB_PERIPH_BASE 12'hb80
`define CPB_CTLREG_BASE 12'hbf8
`define CPB_BOOT_BASE 12'h1fc
`define CPB_ROW_SHIFT 14
`endif

// file: tb/cpb_bridge_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checks on the bridge
module cpb_bridge_assertions (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Watched outputs
   input wire logic [5:0] grant_o,
   input wire logic done_o,
   input wire logic beat_ack_o,
   input wire logic [3:0] byte_lane_select_low_o,
   input wire logic mem_rd_o,
   input wire logic mem_wr_o,
   input wire logic mem_data_oe_n_o,
   input wire logic [11:0] region_sel_o,
   input wire logic [1:0] port_width_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   wire logic act = mem_rd_o | mem_wr_o;
   chk_one_grant: assert property ($onehot0(grant_o))
      else $error("two grants at once");
   chk_grant_hold: assert property (act && $past(act) |-> $stable(grant_o))
      else $error("grant moved inside a transfer");
   chk_write_drive: assert property (mem_wr_o |-> !mem_data_oe_n_o)
      else $error("write data not driven");
   chk_read_float: assert property (mem_rd_o |-> mem_data_oe_n_o && !mem_wr_o)
      else $error("data bus driven during read");
   chk_lanes_low: assert property (act |-> byte_lane_select_low_o == 4'h0)
      else $error("byte lanes not all selected");
   chk_done_ack: assert property (done_o |-> beat_ack_o)
      else $error("done without a word");
   chk_read_gap: assert property ($fell(mem_rd_o) |-> !act [*3])
      else $error("turnaround cut short");
   chk_fixed_width: assert property (act && (|region_sel_o[7:6] ||
      |region_sel_o[3:0]) |-> port_width_o == 2'h2)
      else $error("fixed region not 32 bits");
   chk_one_region: assert property (act |-> $onehot(region_sel_o))
      else $error("region select not one-hot");
endmodule
`default_nettype wire

// file: tb/cpb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// External memory responder
module cpb_mem_model (
   // Clock
   input wire logic ref_clk_i,
   // Bridge pins
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [25:2] addr_i,
   input wire logic [31:0] wdata_i,
   // Response pacing
   input wire logic [3:0] dly_i,
   output logic ready_o,
   output logic [31:0] rdata_o
);
   logic [23:0] aq[$];
   logic [31:0] dq[$];
   int cnt = 0;
   initial ready_o = 1'h0;
   // Released bus shows another pattern, never the last word
   assign rdata_o = rd_i ? {8'h5a, addr_i} : {8'ha5, ~addr_i};
   always @(posedge ref_clk_i) begin
      ready_o <= 1'h0;
      if (!(rd_i | wr_i))
         cnt <= 0;
      else if (cnt == dly_i) begin
         // Gap lets the synchronised ack land before the next word
         ready_o <= 1'h1;
         cnt <= -6;
         aq.push_back(addr_i);
         if (wr_i)
            dq.push_back(wdata_i);
      end else
         cnt <= cnt + 1;
   end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Bench
module testbench import cpb_pkg::*;;
   logic ref_clk_i = 1'h0, rst_i = 1'h1, rr = 1'h0, slow = 1'h0;
   logic ta_load = 1'h0, ack, done, rd, wr, oe_n, rdy;
   logic [23:0] ta = 24'hffffff;
   logic [3:0] mw = 4'h0, dly = 4'h0, bl;
   logic [31:0] cw = 32'h0, dw = 32'h0, rdata, md_in, md_out;
   cpb_window_t dwin [4];
   cpb_window_t mwin [2];
   cpb_req_t req [6];
   logic [5:0] grant;
   logic [25:2] ma;
   logic [15:2] da;
   logic [11:0] rsel;
   logic [1:0] pw;
   int miscompares = 0, tests_run = 0, seed = 29517, cyc = 0;
   cpb_bridge i_cpb_bridge (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .rr_mode_i(rr), .slow_decode_i(slow), .turnaround_count_i(ta),
      .mem_width_i(mw), .ta_load_i(ta_load), .dram_win_i(dwin),
      .mem_win_i(mwin), .req_i(req), .cpu_wdata_i(cw), .dma_wdata_i(dw),
      .grant_o(grant), .beat_ack_o(ack), .done_o(done), .rdata_o(rdata),
      .mem_addr_o(ma), .dram_addr_o(da), .byte_lane_select_low_o(bl),
      .mem_rd_o(rd), .mem_wr_o(wr), .mem_data_i(md_in), .mem_data_o(md_out),
      .mem_data_oe_n_o(oe_n), .mem_ready_i(rdy), .region_sel_o(rsel),
      .port_width_o(pw));
   cpb_mem_model i_cpb_mem_model (.ref_clk_i(ref_clk_i), .rd_i(rd),
      .wr_i(wr), .addr_i(ma), .wdata_i(md_out), .dly_i(dly),
      .ready_o(rdy), .rdata_o(md_in));
   always #5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         results();
      end
   end
   task automatic check(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'h1) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ========================================
   // Transfers against the reference model
   task automatic run(input int i, input logic w, input logic [31:0] a,
         input int n);
      logic [31:0] e;
      logic [3:0] r;
      logic s;
      int k, t;
      logic [23:0] eq[$];
      r = a[28] ? {3'h2, a[24]} : {2'h0, a[25:24]};
      k = 0;
      t = 0;
      s = 1'h0;
      i_cpb_mem_model.aq.delete();
      i_cpb_mem_model.dq.delete();
      for (int j = 0; j < n; j++) begin
         e = (i == 0 && !w) ? {a[31:4], a[3:2] ^ 2'(j), a[1:0]}
            : a + 32'(4 * j);
         eq.push_back(e[25:2]);
      end
      @(negedge ref_clk_i);
      cw = $random(seed);
      dw = $random(seed);
      req[i] = '{1'h1, w, a, 3'(n)};
      while (k < n && t < 500) begin
         @(posedge ref_clk_i);
         #1;
         t++;
         if ((rd | wr) && !s) begin
            s = 1'h1;
            check(rsel === 12'h1 << r, "region select");
            if (r[2])
               check(pw === mw[2 * r[0] +: 2], "port width");
         end
         if (ack) begin
            if (!w)
               check(rdata === {8'h5a, eq[k]}, "read word");
            check(done === (k == n - 1), "done flag");
            k++;
         end
      end
      @(negedge ref_clk_i);
      req[i].valid = 1'h0;
      check(k == n, "beat count");
      foreach (eq[j]) begin
         check(i_cpb_mem_model.aq[j] === eq[j], "address step");
         if (w)
            check(i_cpb_mem_model.dq[j] === (i == 0 ? cw : dw), "wdata");
      end
   endtask
   task automatic batch(input int m);
      int i, b;
      logic [31:0] a;
      logic w;
      for (int j = 0; j < m; j++) begin
         i = $unsigned($random(seed)) % 6;
         b = $unsigned($random(seed)) % 4 + 1;
         a = $random(seed);
         w = a[30];
         a = {3'h0, a[31], 2'h0, a[25] & ~a[31], a[24:0]};
         dly = $random(seed);
         run(i, w, a, b);
      end
   endtask
   task automatic arb(input logic [5:0] m, input logic [5:0] g);
      logic [5:0] h;
      int t;
      repeat (8) @(negedge ref_clk_i);
      for (int i = 0; i < 6; i++)
         if (m[i])
            req[i] = '{1'h1, 1'h0, 32'h40, 3'h1};
      h = m;
      t = 0;
      repeat (2) @(negedge ref_clk_i);
      check(grant === g, "grant order");
      while (h != 6'h0 && t < 900) begin
         @(negedge ref_clk_i);
         t++;
         if (done) begin
            h = h & ~grant;
            for (int i = 0; i < 6; i++)
               if (grant[i])
                  req[i].valid = 1'h0;
         end
      end
      check(h === 6'h0, "all requesters served");
   endtask
   task automatic mode(input logic r, input logic s);
      rr = r;
      slow = s;
      mw = $random(seed);
      rst_i = 1'h1;
      repeat (8) @(negedge ref_clk_i);
      rst_i = 1'h0;
      repeat (2) @(negedge ref_clk_i);
   endtask
   initial begin
      for (int i = 0; i < 6; i++)
         req[i] = '0;
      for (int i = 0; i < 4; i++)
         dwin[i] = '{32'(i) << 24, 32'hffffff};
      for (int i = 0; i < 2; i++)
         mwin[i] = '{32'h10000000 + (32'(i) << 24), 32'hffffff};
      mode(1'h0, 1'h0);
      ta_load = 1'h1;
      @(negedge ref_clk_i);
      ta_load = 1'h0;
      arb(6'h22, 6'h02);
      arb(6'h03, 6'h01);
      arb(6'h30, 6'h10);
      batch(12);
      mode(1'h1, 1'h1);
      arb(6'h06, 6'h02);
      arb(6'h22, 6'h20);
      batch(12);
      results();
   end
endmodule
bind cpb_bridge cpb_bridge_assertions i_chk (.ref_clk_i(ref_clk_i),
   .rst_i(rst_i), .grant_o(grant_o), .done_o(done_o),
   .beat_ack_o(beat_ack_o), .byte_lane_select_low_o(byte_lane_select_low_o),
   .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
   .mem_data_oe_n_o(mem_data_oe_n_o), .region_sel_o(region_sel_o),
   .port_width_o(port_width_o));
`default_nettype wire
